// ==== logic/pbs_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "pbs_defs.svh"
module pbs_top (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wr_addr,
  input  wire logic [7:0]  reg_wr_data,
  input  wire logic [7:0]  reg_rd_addr,
  output logic      [7:0]  reg_rd_data,
  input  wire logic [11:0] line_count,
  input  wire logic [11:0] pixel_count,
  input  wire logic        ext_preblank,
  output logic             preblank_pulse,
  output logic      [1:0]  active_seq
);

  ////////////////////////////////////////////////////////////////////////////
  // register access helpers

  typedef pbs_pkg::pbs_field_t [`PBS_NUM_REGS-1:0] pbs_regs_t;

  function automatic logic in_window(input logic [7:0] addr);
    return (addr >= `PBS_ADDR_BASE) && (addr <= `PBS_ADDR_LAST);
  endfunction

  function automatic logic [4:0] reg_index(input logic [7:0] addr);
    logic [7:0] d;
    d = addr - `PBS_ADDR_BASE;
    return d[4:0];
  endfunction

  function automatic pbs_pkg::pbs_field_t reg_at(input pbs_regs_t r,
                                                 input logic [7:0] addr);
    return r[reg_index(addr)];
  endfunction

  // two 6-bit halves form one 12-bit position, low half first
  function automatic logic [11:0] pos12(input pbs_regs_t r,
                                        input logic [7:0] lo_addr);
    logic [11:0] p;
    p[`PBS_LO_MSB:0]   = reg_at(r, lo_addr);                // [R4]
    p[11:`PBS_HI_LSB]  = reg_at(r, lo_addr + 8'h01);        // [R4]
    return p;
  endfunction

  function automatic logic [7:0] seq_base(input logic [1:0] k);
    return `PBS_OFF_SEQ0_START + `PBS_SEQ_STRIDE * {6'h00, k}; // [R6]
  endfunction

  function automatic logic [7:0] chg_lo(input logic [1:0] k);
    return `PBS_OFF_CHG1_POS_LO + `PBS_CHG_STRIDE * {6'h00, k - 2'h1};
  endfunction

  // narrow fields via a local copy, since a call result cannot be sliced
  function automatic logic [1:0] ptr_at(input pbs_regs_t r,
                                        input logic [7:0] addr);
    pbs_pkg::pbs_field_t f;
    f = reg_at(r, addr);
    return f[1:0];                                          // [R8]
  endfunction

  function automatic logic flag_at(input pbs_regs_t r,
                                   input logic [7:0] addr);
    pbs_pkg::pbs_field_t f;
    f = reg_at(r, addr);
    return f[0];
  endfunction

  // writable bits per register; the rest stay zero and read as zero
  function automatic pbs_pkg::pbs_field_t width_mask(input logic [7:0] a);
    unique case (a)
      `PBS_OFF_SOURCE_SELECT, `PBS_OFF_EXT_POLARITY,
      `PBS_OFF_SEQ0_START, `PBS_OFF_SEQ1_START,
      `PBS_OFF_SEQ2_START, `PBS_OFF_SEQ3_START: return `PBS_W_FLAG;
      `PBS_OFF_CHG0_PTR, `PBS_OFF_CHG1_PTR,
      `PBS_OFF_CHG2_PTR, `PBS_OFF_CHG3_PTR:     return `PBS_W_PTR;
      default:                                 return `PBS_W_POS;
    endcase
  endfunction

  function automatic pbs_pkg::pbs_field_t reset_value(input logic [7:0] a);
    unique case (a)
      `PBS_OFF_SOURCE_SELECT: return `PBS_RST_SOURCE_SELECT;
      `PBS_OFF_EXT_POLARITY:  return `PBS_RST_EXT_POLARITY;
      `PBS_OFF_SEQ0_START:    return `PBS_RST_SEQ0_START;
      `PBS_OFF_SEQ0_TOG1_LO:  return `PBS_RST_SEQ0_TOG1_LO;
      `PBS_OFF_SEQ0_TOG1_HI:  return `PBS_RST_SEQ0_TOG1_HI;
      `PBS_OFF_SEQ0_TOG2_LO:  return `PBS_RST_SEQ0_TOG2_LO;
      `PBS_OFF_SEQ0_TOG2_HI:  return `PBS_RST_SEQ0_TOG2_HI;
      `PBS_OFF_SEQ1_START:    return `PBS_RST_SEQ1_START;
      `PBS_OFF_SEQ1_TOG1_LO:  return `PBS_RST_SEQ1_TOG1_LO;
      `PBS_OFF_SEQ1_TOG1_HI:  return `PBS_RST_SEQ1_TOG1_HI;
      `PBS_OFF_SEQ1_TOG2_LO:  return `PBS_RST_SEQ1_TOG2_LO;
      `PBS_OFF_SEQ1_TOG2_HI:  return `PBS_RST_SEQ1_TOG2_HI;
      `PBS_OFF_SEQ2_START:    return `PBS_RST_SEQ2_START;
      `PBS_OFF_SEQ2_TOG1_LO:  return `PBS_RST_SEQ2_TOG1_LO;
      `PBS_OFF_SEQ2_TOG1_HI:  return `PBS_RST_SEQ2_TOG1_HI;
      `PBS_OFF_SEQ2_TOG2_LO:  return `PBS_RST_SEQ2_TOG2_LO;
      `PBS_OFF_SEQ2_TOG2_HI:  return `PBS_RST_SEQ2_TOG2_HI;
      `PBS_OFF_SEQ3_START:    return `PBS_RST_SEQ3_START;
      `PBS_OFF_SEQ3_TOG1_LO:  return `PBS_RST_SEQ3_TOG1_LO;
      `PBS_OFF_SEQ3_TOG1_HI:  return `PBS_RST_SEQ3_TOG1_HI;
      `PBS_OFF_SEQ3_TOG2_LO:  return `PBS_RST_SEQ3_TOG2_LO;
      `PBS_OFF_SEQ3_TOG2_HI:  return `PBS_RST_SEQ3_TOG2_HI;
      `PBS_OFF_CHG0_PTR:      return `PBS_RST_CHG0_PTR;     // [R9]
      `PBS_OFF_CHG1_POS_LO:   return `PBS_RST_CHG1_POS_LO;
      `PBS_OFF_CHG1_POS_HI:   return `PBS_RST_CHG1_POS_HI;
      `PBS_OFF_CHG1_PTR:      return `PBS_RST_CHG1_PTR;
      `PBS_OFF_CHG2_POS_LO:   return `PBS_RST_CHG2_POS_LO;
      `PBS_OFF_CHG2_POS_HI:   return `PBS_RST_CHG2_POS_HI;
      `PBS_OFF_CHG2_PTR:      return `PBS_RST_CHG2_PTR;
      `PBS_OFF_CHG3_POS_LO:   return `PBS_RST_CHG3_POS_LO;
      `PBS_OFF_CHG3_POS_HI:   return `PBS_RST_CHG3_POS_HI;
      `PBS_OFF_CHG3_PTR:      return `PBS_RST_CHG3_PTR;
      default:                return 6'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state and decoded fields

  pbs_pkg::pbs_state_t state;
  pbs_pkg::pbs_state_t next_state;

  pbs_pkg::pbs_src_t   source;
  logic                ext_high_active;
  logic [1:0]          sel_seq;
  logic                sel_start;
  logic [11:0]         sel_first;
  logic [11:0]         sel_second;
  logic [11:0]         chg_pos1;
  logic [11:0]         chg_pos2;
  logic [11:0]         chg_pos3;
  logic                line_start;
  logic                int_next;

  // control bits decoded from the register file
  always_comb begin
    source = pbs_pkg::pbs_src_t'(reg_at(state.regs,
                                        `PBS_OFF_SOURCE_SELECT) != 6'h00);
    ext_high_active = reg_at(state.regs, `PBS_OFF_EXT_POLARITY) != 6'h00;
    chg_pos1 = pos12(state.regs, chg_lo(2'h1));                 // [R9]
    chg_pos2 = pos12(state.regs, chg_lo(2'h2));
    chg_pos3 = pos12(state.regs, chg_lo(2'h3));
    line_start = (pixel_count == 12'h000);
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequence choice: only re-evaluated at line start, so a line never
  // switches sequence halfway through its toggles

  logic [1:0] seq_candidate;

  pbs_seq_select u_seq_select (
    .line_count        (line_count),
    .change_position_1 (chg_pos1),
    .change_position_2 (chg_pos2),
    .change_position_3 (chg_pos3),
    .pointer_0         (ptr_at(state.regs, `PBS_OFF_CHG0_PTR)),
    .pointer_1         (ptr_at(state.regs, `PBS_OFF_CHG1_PTR)),
    .pointer_2         (ptr_at(state.regs, `PBS_OFF_CHG2_PTR)),
    .pointer_3         (ptr_at(state.regs, `PBS_OFF_CHG3_PTR)),
    .current_seq       (state.active_seq),
    .next_seq          (seq_candidate)
  );

  // fields of the sequence in force for this pixel
  always_comb begin
    sel_seq    = line_start ? seq_candidate : state.active_seq; // [R11]
    sel_start  = flag_at(state.regs, seq_base(sel_seq));        // [R3]
    sel_first  = pos12(state.regs, seq_base(sel_seq) + 8'h01);  // [R4]
    sel_second = pos12(state.regs, seq_base(sel_seq) + 8'h03);  // [R5]
  end

  pbs_level_gen u_level_gen (
    .pixel_count   (pixel_count),
    .start_level   (sel_start),
    .first_toggle  (sel_first),
    .second_toggle (sel_second),
    .level         (state.int_level),
    .next_level    (int_next)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_state = state;
    next_state.active_seq = sel_seq;
    next_state.int_level  = int_next;
    // external pin is normalised to an active-high pulse
    if (source == pbs_pkg::PBS_SRC_EXTERNAL) begin              // [R1]
      next_state.pulse = ext_high_active ? ext_preblank         // [R2]
                                         : ~ext_preblank;
    end else begin
      next_state.pulse = int_next;                              // [R10]
    end
    // writes outside the window are dropped silently
    if (reg_wr_en && in_window(reg_wr_addr)) begin
      next_state.regs[reg_index(reg_wr_addr)] =
        reg_wr_data[5:0] & width_mask(reg_wr_addr);
    end
    // unmapped reads return zero
    if (in_window(reg_rd_addr)) begin
      next_state.rd_data = {2'b00, reg_at(state.regs, reg_rd_addr)};
    end else begin
      next_state.rd_data = 8'h00;
    end
    if (srst) begin
      for (int i = 0; i < `PBS_NUM_REGS; i++) begin
        next_state.regs[i] = reset_value(`PBS_ADDR_BASE + 8'(i));
      end
      next_state.active_seq = 2'h0;
      next_state.int_level  = 1'b0;
      next_state.pulse      = 1'b0;
      next_state.rd_data    = 8'h00;
    end
  end

  // single register stage for all state
  always_ff @(posedge sys_clk) begin
    state <= next_state;
  end

  assign reg_rd_data    = state.rd_data;
  assign preblank_pulse = state.pulse;
  assign active_seq     = state.active_seq;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  logic ext_mode;
  logic [11:0] a_first;
  logic [11:0] a_second;
  logic [11:0] a_seq0_first;
  logic [11:0] a_seq3_first;
  assign ext_mode = (source == pbs_pkg::PBS_SRC_EXTERNAL);
  assign a_first  = pos12(state.regs, seq_base(state.active_seq) + 8'h01);
  assign a_second = pos12(state.regs, seq_base(state.active_seq) + 8'h03);
  assign a_seq0_first = pos12(state.regs, `PBS_OFF_SEQ0_TOG1_LO);
  assign a_seq3_first = pos12(state.regs, `PBS_OFF_SEQ3_TOG1_LO);

  sequence s_write_seq0_tog1_lo;
    reg_wr_en && (reg_wr_addr == `PBS_OFF_SEQ0_TOG1_LO);
  endsequence

  sequence s_line_one_match;
    line_start && (line_count == chg_pos1) &&
    (line_count != chg_pos2) && (line_count != chg_pos3);
  endsequence

  sequence s_line_two_match;
    line_start && (line_count == chg_pos2) && (line_count != chg_pos3);
  endsequence

  sequence s_line_three_match;
    line_start && (line_count == chg_pos3);
  endsequence

  sequence s_write_seq3_tog1_hi;
    reg_wr_en && (reg_wr_addr == `PBS_OFF_SEQ3_TOG1_HI);
  endsequence

  // reset is the trigger here, so the default disable must not apply
  chk_reset_defaults: assert property (@(posedge sys_clk) // [R1] [R9]
    disable iff (1'b0)
    srst |=> (source == pbs_pkg::PBS_SRC_EXTERNAL) &&
             (reg_at(state.regs, `PBS_OFF_CHG0_PTR) == 6'h02))
    else $error("reset did not select external source and sequence 2");

  chk_reset_outputs: assert property (@(posedge sys_clk) // [R1]
    disable iff (1'b0)
    srst |=> !preblank_pulse && (active_seq == 2'h0) &&
             (reg_rd_data == 8'h00))
    else $error("reset did not clear the outputs");

  chk_ext_high_pol: assert property ( // [R2]
    ext_mode && ext_high_active && !reg_wr_en |=>
      preblank_pulse == $past(ext_preblank))
    else $error("high active external pulse not passed through");

  chk_ext_low_pol: assert property ( // [R2]
    ext_mode && !ext_high_active && !reg_wr_en |=>
      preblank_pulse != $past(ext_preblank))
    else $error("low active external pulse not inverted");

  chk_start_level: assert property ( // [R3]
    !ext_mode && !reg_wr_en && line_start && (sel_first != 12'h000) &&
    (sel_second != 12'h000) |=> preblank_pulse == $past(sel_start))
    else $error("line did not begin at the start level");

  chk_toggle_hit: assert property ( // [R4] [R5] [R10]
    !ext_mode && !reg_wr_en && !line_start &&
    ((pixel_count == a_first) || (pixel_count == a_second)) |=>
      preblank_pulse != $past(state.int_level))
    else $error("output did not invert at a toggle position");

  // the pulse may still hold the pin value just after a source switch
  chk_toggle_hold: assert property ( // [R10]
    !ext_mode && !reg_wr_en && !line_start &&
    (pixel_count != a_first) && (pixel_count != a_second) |=>
      preblank_pulse == $past(state.int_level))
    else $error("output changed away from a toggle position");

  chk_change_pos_one: assert property ( // [R8] [R11]
    s_line_one_match |=>
      active_seq == $past(ptr_at(state.regs, `PBS_OFF_CHG1_PTR)))
    else $error("change position 1 did not select its sequence");

  chk_change_pos_two: assert property ( // [R8] [R11]
    s_line_two_match |=>
      active_seq == $past(ptr_at(state.regs, `PBS_OFF_CHG2_PTR)))
    else $error("change position 2 did not select its sequence");

  chk_change_pos_three: assert property ( // [R8] [R11]
    s_line_three_match |=>
      active_seq == $past(ptr_at(state.regs, `PBS_OFF_CHG3_PTR)))
    else $error("change position 3 did not select its sequence");

  chk_change_zero: assert property ( // [R7]
    line_start && (line_count == 12'h000) && (chg_pos1 != 12'h000) &&
    (chg_pos2 != 12'h000) && (chg_pos3 != 12'h000) |=>
      active_seq == $past(ptr_at(state.regs, `PBS_OFF_CHG0_PTR)))
    else $error("position zero did not apply pointer 0");

  chk_seq_mid_line: assert property ( // [R6] [R11]
    !line_start |=> active_seq == $past(active_seq))
    else $error("sequence changed in the middle of a line");

  chk_write_lo: assert property ( // [R4]
    s_write_seq0_tog1_lo |=>
      a_seq0_first[`PBS_LO_MSB:0] == $past(reg_wr_data[5:0]))
    else $error("low toggle half not stored");

  chk_write_hi: assert property ( // [R4]
    s_write_seq3_tog1_hi |=>
      a_seq3_first[11:`PBS_HI_LSB] == $past(reg_wr_data[5:0]))
    else $error("high toggle half not stored");

  // bits above the pointer field must stay zero
  chk_ptr_write: assert property ( // [R8]
    reg_wr_en && (reg_wr_addr == `PBS_OFF_CHG0_PTR) |=>
      reg_at(state.regs, `PBS_OFF_CHG0_PTR) ==
      {4'h0, $past(reg_wr_data[1:0])})
    else $error("pointer write not stored at two bits");

endmodule // pbs_top
`default_nettype wire

// ==== logic/pbs_defs.svh ====
// What this block does
// [R1] source bit 0 internal, 1 external; reset external
// [R2] external input polarity: 0 low, 1 high
// [R3] start level drives output at line start
// [R4] first toggle: low reg 5:0, high 11:6
// [R5] second toggle, split the same way, toggles again
// [R6] four independent sequences, numbered 0 to 3
// [R7] change position zero fixed at zero
// [R8] each change position has 2-bit sequence pointer
// [R9] positions 1-3 programmable; pointer 0 resets to 2
// [R10] internal output inverts at either toggle position
// [R11] active sequence changes when line reaches position
`ifndef PBS_DEFS_SVH
`define PBS_DEFS_SVH

// register window and field geometry
`define PBS_ADDR_BASE        8'hc5
`define PBS_ADDR_LAST        8'he4
`define PBS_NUM_REGS         32
`define PBS_LO_MSB           5
`define PBS_HI_LSB           6
`define PBS_W_FLAG           6'h01
`define PBS_W_PTR            6'h03
`define PBS_W_POS            6'h3f
`define PBS_SEQ_STRIDE       8'h05
`define PBS_CHG_STRIDE       8'h03
`define PBS_CHG0_POSITION    12'h000

// offsets
`define PBS_OFF_SOURCE_SELECT 8'hc5
`define PBS_OFF_EXT_POLARITY  8'hc6
`define PBS_OFF_SEQ0_START    8'hc7
`define PBS_OFF_SEQ0_TOG1_LO  8'hc8
`define PBS_OFF_SEQ0_TOG1_HI  8'hc9
`define PBS_OFF_SEQ0_TOG2_LO  8'hca
`define PBS_OFF_SEQ0_TOG2_HI  8'hcb
`define PBS_OFF_SEQ1_START    8'hcc
`define PBS_OFF_SEQ1_TOG1_LO  8'hcd
`define PBS_OFF_SEQ1_TOG1_HI  8'hce
`define PBS_OFF_SEQ1_TOG2_LO  8'hcf
`define PBS_OFF_SEQ1_TOG2_HI  8'hd0
`define PBS_OFF_SEQ2_START    8'hd1
`define PBS_OFF_SEQ2_TOG1_LO  8'hd2
`define PBS_OFF_SEQ2_TOG1_HI  8'hd3
`define PBS_OFF_SEQ2_TOG2_LO  8'hd4
`define PBS_OFF_SEQ2_TOG2_HI  8'hd5
`define PBS_OFF_SEQ3_START    8'hd6
`define PBS_OFF_SEQ3_TOG1_LO  8'hd7
`define PBS_OFF_SEQ3_TOG1_HI  8'hd8
`define PBS_OFF_SEQ3_TOG2_LO  8'hd9
`define PBS_OFF_SEQ3_TOG2_HI  8'hda
`define PBS_OFF_CHG0_PTR      8'hdb
`define PBS_OFF_CHG1_POS_LO   8'hdc
`define PBS_OFF_CHG1_POS_HI   8'hdd
`define PBS_OFF_CHG1_PTR      8'hde
`define PBS_OFF_CHG2_POS_LO   8'hdf
`define PBS_OFF_CHG2_POS_HI   8'he0
`define PBS_OFF_CHG2_PTR      8'he1
`define PBS_OFF_CHG3_POS_LO   8'he2
`define PBS_OFF_CHG3_POS_HI   8'he3
`define PBS_OFF_CHG3_PTR      8'he4

// reset values
`define PBS_RST_SOURCE_SELECT 6'h01
`define PBS_RST_EXT_POLARITY  6'h00
`define PBS_RST_SEQ0_START    6'h01
`define PBS_RST_SEQ0_TOG1_LO  6'h3d
`define PBS_RST_SEQ0_TOG1_HI  6'h00
`define PBS_RST_SEQ0_TOG2_LO  6'h2a
`define PBS_RST_SEQ0_TOG2_HI  6'h06
`define PBS_RST_SEQ1_START    6'h00
`define PBS_RST_SEQ1_TOG1_LO  6'h2a
`define PBS_RST_SEQ1_TOG1_HI  6'h06
`define PBS_RST_SEQ1_TOG2_LO  6'h3f
`define PBS_RST_SEQ1_TOG2_HI  6'h3f
`define PBS_RST_SEQ2_START    6'h00
`define PBS_RST_SEQ2_TOG1_LO  6'h3f
`define PBS_RST_SEQ2_TOG1_HI  6'h3f
`define PBS_RST_SEQ2_TOG2_LO  6'h3f
`define PBS_RST_SEQ2_TOG2_HI  6'h3f
`define PBS_RST_SEQ3_START    6'h01
`define PBS_RST_SEQ3_TOG1_LO  6'h3f
`define PBS_RST_SEQ3_TOG1_HI  6'h3f
`define PBS_RST_SEQ3_TOG2_LO  6'h3f
`define PBS_RST_SEQ3_TOG2_HI  6'h3f
`define PBS_RST_CHG0_PTR      6'h02
`define PBS_RST_CHG1_POS_LO   6'h01
`define PBS_RST_CHG1_POS_HI   6'h00
`define PBS_RST_CHG1_PTR      6'h01
`define PBS_RST_CHG2_POS_LO   6'h02
`define PBS_RST_CHG2_POS_HI   6'h00
`define PBS_RST_CHG2_PTR      6'h00
`define PBS_RST_CHG3_POS_LO   6'h37
`define PBS_RST_CHG3_POS_HI   6'h03
`define PBS_RST_CHG3_PTR      6'h02

`endif

// ==== logic/pbs_pkg.sv ====
`include "pbs_defs.svh"
package pbs_pkg;

  typedef logic [5:0] pbs_field_t;

  // where the pulse comes from
  typedef enum logic {
    PBS_SRC_INTERNAL = 1'b0,
    PBS_SRC_EXTERNAL = 1'b1
  } pbs_src_t;

  // whole state of the top module
  typedef struct packed {
    pbs_field_t [`PBS_NUM_REGS-1:0] regs;
    logic [1:0]                     active_seq;
    logic                           int_level;
    logic                           pulse;
    logic [7:0]                     rd_data;
  } pbs_state_t;

endpackage

// ==== logic/pbs_level_gen.sv ====
`timescale 1ns/1ns
`default_nettype none
module pbs_level_gen (
  input  wire logic [11:0] pixel_count,
  input  wire logic        start_level,
  input  wire logic [11:0] first_toggle,
  input  wire logic [11:0] second_toggle,
  input  wire logic        level,
  output logic             next_level
);
  logic base;
  logic hit;

  // line start reloads the start level; both positions equal toggle once
  always_comb begin
    base = (pixel_count == 12'h000) ? start_level : level; // [R3]
    hit  = (pixel_count == first_toggle) ||                // [R4]
           (pixel_count == second_toggle);                 // [R5]
    next_level = base ^ hit;                               // [R10]
  end
endmodule // pbs_level_gen
`default_nettype wire

// ==== logic/pbs_seq_select.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "pbs_defs.svh"
module pbs_seq_select (
  input  wire logic [11:0] line_count,
  input  wire logic [11:0] change_position_1,
  input  wire logic [11:0] change_position_2,
  input  wire logic [11:0] change_position_3,
  input  wire logic [1:0]  pointer_0,
  input  wire logic [1:0]  pointer_1,
  input  wire logic [1:0]  pointer_2,
  input  wire logic [1:0]  pointer_3,
  input  wire logic [1:0]  current_seq,
  output logic      [1:0]  next_seq
);
  // later positions win when several match the same line
  always_comb begin
    next_seq = current_seq;
    if (line_count == `PBS_CHG0_POSITION) begin // [R7]
      next_seq = pointer_0;                     // [R8]
    end
    if (line_count == change_position_1) begin  // [R11]
      next_seq = pointer_1;
    end
    if (line_count == change_position_2) begin
      next_seq = pointer_2;
    end
    if (line_count == change_position_3) begin
      next_seq = pointer_3;
    end
  end
endmodule // pbs_seq_select
`default_nettype wire

// ==== sim/pbs_timing_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// stands in for the timing core and the external blanking source
module pbs_timing_model #(
  parameter int LINE_PIXELS = 500
) (
  input  wire logic        sys_clk,
  input  wire logic        line_go,
  input  wire logic [11:0] line_num,
  input  wire logic        ext_level,
  output logic      [11:0] line_count,
  output logic      [11:0] pixel_count,
  output logic             ext_preblank
);
  logic running;

  ////////////////////////////////////////////////////////////////////////////
  // counters move on the falling edge, so they are settled at sampling
  initial begin
    line_count  = 12'h000;
    pixel_count = 12'(LINE_PIXELS - 1); // idle off line start
    running     = 1'b0;
  end

  // a line always restarts the pixel count at zero, then counts up once
  always @(negedge sys_clk) begin
    if (line_go) begin
      line_count  <= line_num;
      pixel_count <= 12'h000;
      running     <= 1'b1;
    end else if (running) begin
      if (pixel_count == 12'(LINE_PIXELS - 1)) begin
        running <= 1'b0; // park on last pixel, no false line start
      end else begin
        pixel_count <= pixel_count + 12'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the external pin is a plain driven level, never released
  assign ext_preblank = ext_level;
endmodule // pbs_timing_model
`default_nettype wire

// ==== sim/pbs_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`define TB_CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module preblank_pulse_sequencer_tb_top;
  localparam int PIX = 500; // long enough to pass the default toggles
  logic        sys_clk;
  logic        srst;
  logic        reg_wr_en;
  logic [7:0]  reg_wr_addr;
  logic [7:0]  reg_wr_data;
  logic [7:0]  reg_rd_addr;
  logic [7:0]  reg_rd_data;
  logic [11:0] line_count;
  logic [11:0] pixel_count;
  logic        ext_preblank;
  logic        preblank_pulse;
  logic [1:0]  active_seq;
  logic        line_go;
  logic [11:0] line_num;
  logic        ext_level;
  int          error_cnt;
  int          check_count;
  // reset image of the window 0xc5..0xe4
  logic [7:0]  rst_tab [32] = '{8'h01, 8'h00, 8'h01, 8'h3d, 8'h00, 8'h2a,
    8'h06, 8'h00, 8'h2a, 8'h06, 8'h3f, 8'h3f, 8'h00, 8'h3f, 8'h3f, 8'h3f,
    8'h3f, 8'h01, 8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h02, 8'h01, 8'h00, 8'h01,
    8'h02, 8'h00, 8'h00, 8'h37, 8'h03, 8'h02};
  // shadow of the sequences as the bench has programmed them
  logic        st [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic [11:0] t1 [4] = '{12'h03d, 12'h1aa, 12'hfff, 12'hfff};
  logic [11:0] t2 [4] = '{12'h1aa, 12'hfff, 12'hfff, 12'hfff};

  pbs_top pbs_top_i (
    .sys_clk(sys_clk), .srst(srst), .reg_wr_en(reg_wr_en),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
    .line_count(line_count), .pixel_count(pixel_count),
    .ext_preblank(ext_preblank), .preblank_pulse(preblank_pulse),
    .active_seq(active_seq));

  pbs_timing_model #(.LINE_PIXELS(PIX)) pbs_timing_model_i (
    .sys_clk(sys_clk), .line_go(line_go), .line_num(line_num),
    .ext_level(ext_level), .line_count(line_count),
    .pixel_count(pixel_count), .ext_preblank(ext_preblank));

  ////////////////////////////////////////////////////////////////////////////
  // clock and shared tasks
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr_en   = 1'b1;
    reg_wr_addr = a;
    reg_wr_data = d;
    @(negedge sys_clk);
    reg_wr_en = 1'b0; // one idle cycle between writes
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    reg_rd_addr = a;
    @(posedge sys_clk);
    #1;
    `TB_CHK(reg_rd_data, e)
  endtask

  // level after pixel p: start level, flipped once per distinct toggle
  function automatic logic exp_lvl(input logic [1:0] s,
                                   input logic [11:0] p);
    return st[s] ^ (p >= t1[s]) ^ ((p >= t2[s]) && (t2[s] != t1[s]));
  endfunction

  // the new sequence applies from pixel zero of the line; pulse checks are optional per pass
  task automatic run_line(input logic [11:0] ln, input logic [1:0] s,
                          input bit chk);
    logic [11:0] p;
    @(negedge sys_clk);
    line_go  <= 1'b1;
    line_num <= ln;
    @(negedge sys_clk);
    line_go <= 1'b0;
    repeat (PIX) begin
      @(posedge sys_clk);
      p = pixel_count;
      #1;
      if (chk) `TB_CHK(preblank_pulse, exp_lvl(s, p)) // pulse level
    end
    `TB_CHK(active_seq, s) // sequence in force
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_values();
    for (int i = 0; i < 32; i++) begin
      rd_chk(8'(8'hc5 + i), rst_tab[i]); // defaults
    end
    rd_chk(8'hc4, 8'h00); // below the window
    rd_chk(8'he5, 8'h00); // above the window
  endtask

  task automatic t_field_width();
    logic [7:0] tab [4][3] = '{'{8'hc6, 8'h01, 8'h00},
      '{8'hc8, 8'h3f, 8'h3d}, '{8'hdb, 8'h03, 8'h02},
      '{8'he5, 8'h00, 8'h00}};
    for (int i = 0; i < 4; i++) begin
      wr(tab[i][0], 8'hff);
      rd_chk(tab[i][0], tab[i][1]); // field widths
      wr(tab[i][0], tab[i][2]);
    end
  endtask

  task automatic t_external();
    for (int pol = 0; pol < 2; pol++) begin
      wr(8'hc6, 8'(pol));
      for (int lv = 0; lv < 2; lv++) begin
        @(negedge sys_clk);
        ext_level = lv[0];
        @(posedge sys_clk);
        #1;
        `TB_CHK(preblank_pulse, lv[0] ~^ pol[0]) // pin polarity
      end
    end
    wr(8'hc6, 8'h00);
  endtask

  task automatic t_internal_default();
    wr(8'hc5, 8'h00);
    run_line(12'h000, 2'd2, 1'b0); // position zero, pointer reset
    run_line(12'h000, 2'd2, 1'b1); // start level only
    run_line(12'h001, 2'd1, 1'b0); // change position one
    run_line(12'h001, 2'd1, 1'b1); // one toggle in line
    run_line(12'h002, 2'd0, 1'b0); // change position two
    run_line(12'h002, 2'd0, 1'b1); // two toggles in line
    run_line(12'h005, 2'd0, 1'b0); // no match keeps sequence
    run_line(12'h0f7, 2'd2, 1'b0); // 12-bit change position
  endtask

  task automatic t_program();
    wr(8'hd6, 8'h00);
    wr(8'hd7, 8'h05);
    wr(8'hd8, 8'h02);
    wr(8'hd9, 8'h3f);
    wr(8'hda, 8'h05);
    st[3] = 1'b0;
    t1[3] = 12'h085;
    t2[3] = 12'h17f;
    wr(8'he2, 8'h01);
    wr(8'he3, 8'h01);
    wr(8'he4, 8'h03);
    run_line(12'h041, 2'd3, 1'b0); // pointer three to sequence three
    run_line(12'h041, 2'd3, 1'b1); // split toggles assembled
    wr(8'hdb, 8'h01);
    run_line(12'h000, 2'd1, 1'b0); // pointer zero reprogrammed
    wr(8'hc5, 8'h01);
    @(negedge sys_clk);
    ext_level = 1'b1;
    @(posedge sys_clk);
    #1;
    `TB_CHK(preblank_pulse, 1'b0) // back on the pin
  endtask

  // reset in mid run must restore the documented defaults
  task automatic t_reset_mid();
    @(negedge sys_clk);
    srst = 1'b1;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    `TB_CHK(active_seq, 2'd0) // cleared by reset
    `TB_CHK(preblank_pulse, 1'b0) // cleared by reset
    rd_chk(8'hdb, 8'h02); // pointer zero back to 2
    rd_chk(8'hc5, 8'h01); // source back to external
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // verdict, main sequence and watchdog
  task automatic summarize();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    error_cnt   = 0;
    check_count = 0;
    srst        = 1'b1;
    reg_wr_en   = 1'b0;
    reg_wr_addr = 8'h00;
    reg_wr_data = 8'h00;
    reg_rd_addr = 8'h00;
    line_go     = 1'b0;
    line_num    = 12'h000;
    ext_level   = 1'b0;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 1'b0;
    t_reset_values();
    t_field_width();
    t_external();
    t_internal_default();
    t_program();
    t_reset_mid();
    summarize();
  end

  // whole run needs about 5600 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    summarize();
  end
endmodule // preblank_pulse_sequencer_tb_top
`default_nettype wire
